/* src/nibble_core_pkg.sv */
/*
  Constants and types for the nibble core transfer and skip block.
  Assumes a single instruction clock and an external decoder supplying op codes.
*/
package nibble_core_pkg;
  localparam int ACC_W = 4;
  localparam int X_W = 4;
  localparam int Y_W = 4;
  localparam int Z_W = 2;
  localparam int PTR_W = 10;
  localparam int PAGE_W = 7;
  localparam int PC_W = 14;
  localparam int STK_DEPTH = 8;
  localparam int STK_IDX_W = 3;
  localparam int D_W = 3;
  localparam int E_W = 8;
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  localparam logic [ACC_W-1:0] NIB_ZERO = 4'h0;

  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_B_TO_ACC = 4'b0001,
    OP_ACC_TO_B = 4'b0010,
    OP_Y_TO_ACC = 4'b0011,
    OP_ACC_TO_Y = 4'b0100,
    OP_BA_TO_E = 4'b0101,
    OP_E_TO_BA = 4'b0110,
    OP_ACC_TO_D = 4'b0111,
    OP_D_TO_ACC = 4'b1000,
    OP_Z_TO_ACC = 4'b1001,
    OP_IDX_TO_ACC = 4'b1010,
    OP_X_TO_ACC = 4'b1011,
    OP_RAM_XOR_X = 4'b1100,
    OP_TABLE_REF = 4'b1101,
    OP_CALL = 4'b1110,
    OP_RET = 4'b1111
  } op_t;
endpackage

/* src/return_stack_mem.sv */
/*
  Return stack storage: eight entries of instruction counter width.
  Assumes the caller supplies a write strobe that is already gated by nullify.
*/
`timescale 1ns/100ps
module return_stack_mem (
  input wire logic mclk_i, // Core clock
  input wire logic we_i, // Write strobe
  input wire logic [nibble_core_pkg::STK_IDX_W-1:0] idx_i, // Entry select
  input wire logic [nibble_core_pkg::PC_W-1:0] wdata_i, // Entry to store
  output logic [nibble_core_pkg::PC_W-1:0] rdata_o // Selected entry
);
  import nibble_core_pkg::*;
  logic [PC_W-1:0] return_stack [STK_DEPTH];

  // Store on strobe
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      return_stack[idx_i] <= wdata_i;
    end
  end

  // Read selected entry
  assign rdata_o = return_stack[idx_i];
endmodule

/* src/nibble_cpu_transfer_skip.sv */
/*
  Execution slice of a 4-bit core: pointers, return stack, register transfers and
  skip by nullification. Assumes the decoder gives one op per start pulse and
  that RAM read data for the ram pointer is valid during the op.
*/
`timescale 1ns/100ps
// Summary of operation
// - RAM pointer is Z, Y, X concatenated
// - 14-bit counter, 7-bit page and address
// - Eight 14-bit return entries, 3-bit index
// - Skip nullifies next instruction, no jump
// - Nullified instruction keeps its normal cycles
// - Nullified lookup or return takes one cycle
// - B and accumulator copy both ways
// - Y and accumulator copy both ways
// - B and accumulator written into E halves
// - Z into accumulator low, bit 3 cleared
// - Stack index into accumulator, bit 3 cleared
// - D transfers move accumulator bits 2-0 only
// - RAM load then X xor immediate
module nibble_cpu_transfer_skip (
  input wire logic mclk_i, // 40 MHz core clock
  input wire logic resetn_i, // Sync reset, active low
  input wire logic start_i, // New op presented
  input wire nibble_core_pkg::op_t op_i, // Op code
  input wire logic [3:0] imm_i, // Immediate j
  input wire logic [nibble_core_pkg::PC_W-1:0] target_i, // Call target
  input wire logic skip_i, // Skip condition met now
  input wire logic [1:0] cycles_i, // Normal cycle count, 1 to 3
  input wire logic [3:0] ram_rdata_i, // RAM word at pointer
  output logic busy_o, // Op in progress
  output logic done_o, // Op finished pulse
  output logic nullified_o, // Finished op was nullified
  output logic [nibble_core_pkg::PTR_W-1:0] ram_pointer_o, // RAM address
  output logic [nibble_core_pkg::PC_W-1:0] instruction_counter_o, // Program address
  output logic [3:0] acc_o, // Accumulator
  output logic [3:0] b_o, // Register B
  output logic [7:0] e_o, // Register E
  output logic [2:0] d_register_o, // Register D
  output logic [2:0] return_stack_index_o // Stack index
);
  import nibble_core_pkg::*;

  logic [ACC_W-1:0] acc_q, b_q, x_q, y_q;
  logic [Z_W-1:0] z_q;
  logic [E_W-1:0] e_q;
  logic [D_W-1:0] d_q;
  logic [STK_IDX_W-1:0] sp_q;
  logic [PAGE_W-1:0] pc_page_q, pc_addr_q;
  logic [PC_W-1:0] pc_d, stk_rdata;
  logic skip_pend_q, null_q, busy_q;
  logic [1:0] cnt_q;
  op_t op_q;
  logic [3:0] imm_q;
  logic [PC_W-1:0] target_q;
  logic last, exec, stk_we;
  logic [STK_IDX_W-1:0] stk_idx;
  logic [PC_W-1:0] pc_inc;

  assign instruction_counter_o = {pc_page_q, pc_addr_q};
  assign pc_inc = instruction_counter_o + 14'h0001;
  assign ram_pointer_o = {z_q, y_q, x_q};
  assign last = busy_q && (cnt_q == 2'h0);
  assign exec = last && !null_q;
  assign stk_we = exec && (op_q == OP_CALL);
  assign busy_o = busy_q;
  assign done_o = last;
  assign nullified_o = last && null_q;
  assign acc_o = acc_q;
  assign b_o = b_q;
  assign e_o = e_q;
  assign d_register_o = d_q;
  assign return_stack_index_o = sp_q;

  // push lands one above index, pop reads at it
  assign stk_idx = stk_we ? sp_q + 3'h1 : sp_q;

  return_stack_mem u_stack (
    .mclk_i(mclk_i),
    .we_i(stk_we),
    .idx_i(stk_idx),
    .wdata_i(pc_inc),
    .rdata_o(stk_rdata)
  );

  // Op capture and cycle counting
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
      null_q <= 1'b0;
      op_q <= OP_NOP;
      imm_q <= 4'h0;
      target_q <= PC_RESET;
    end else if (start_i && !busy_q) begin
      busy_q <= 1'b1;
      op_q <= op_i;
      imm_q <= imm_i;
      target_q <= target_i;
      null_q <= skip_pend_q;
      // nullified lookup or return, one cycle
      if (skip_pend_q && (op_i == OP_TABLE_REF || op_i == OP_RET)) begin
        cnt_q <= 2'h0;
      end else begin
        cnt_q <= (cycles_i == 2'h0) ? 2'h0 : cycles_i - 2'h1;
      end
    end else if (last) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end

  // skip marks the next op for nullify
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      skip_pend_q <= 1'b0;
    end else if (start_i && !busy_q) begin
      skip_pend_q <= 1'b0;
    end else if (exec && skip_i) begin
      skip_pend_q <= 1'b1;
    end
  end

  // Counter update: plus one, call, return
  always_comb begin
    pc_d = pc_inc;
    if (exec && op_q == OP_CALL) begin
      pc_d = target_q;
    end else if (exec && op_q == OP_RET) begin
      pc_d = stk_rdata;
    end
  end

  // nullified op still advances by one only
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pc_page_q <= PC_RESET[PC_W-1:PAGE_W];
      pc_addr_q <= PC_RESET[PAGE_W-1:0];
    end else if (last) begin
      pc_page_q <= pc_d[PC_W-1:PAGE_W];
      pc_addr_q <= pc_d[PAGE_W-1:0];
    end
  end

  // Stack index movement
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sp_q <= 3'h7;
    end else if (exec && op_q == OP_CALL) begin
      sp_q <= sp_q + 3'h1;
    end else if (exec && op_q == OP_RET) begin
      sp_q <= sp_q - 3'h1;
    end
  end

  // Accumulator transfers
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      acc_q <= NIB_ZERO;
    end else if (exec) begin
      unique case (op_q)
        OP_B_TO_ACC: acc_q <= b_q;
        OP_Y_TO_ACC: acc_q <= y_q;
        OP_E_TO_BA: acc_q <= e_q[3:0];
        OP_D_TO_ACC: acc_q[2:0] <= d_q;
        OP_Z_TO_ACC: acc_q <= {1'b0, acc_q[2], z_q};
        OP_IDX_TO_ACC: acc_q <= {1'b0, sp_q};
        OP_X_TO_ACC: acc_q <= x_q;
        OP_RAM_XOR_X: acc_q <= ram_rdata_i;
        default: acc_q <= acc_q;
      endcase
    end
  end

  // B, Y, E, D and X updates
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      b_q <= NIB_ZERO;
      y_q <= NIB_ZERO;
      x_q <= NIB_ZERO;
      z_q <= 2'h0;
      e_q <= 8'h00;
      d_q <= 3'h0;
    end else if (exec) begin
      if (op_q == OP_ACC_TO_B) begin
        b_q <= acc_q;
      end
      if (op_q == OP_ACC_TO_Y) begin
        y_q <= acc_q;
      end
      if (op_q == OP_BA_TO_E) begin
        e_q <= {b_q, acc_q};
      end
      if (op_q == OP_E_TO_BA) begin
        b_q <= e_q[7:4];
      end
      if (op_q == OP_ACC_TO_D) begin
        d_q <= acc_q[2:0];
      end
      if (op_q == OP_RAM_XOR_X) begin
        x_q <= x_q ^ imm_q;
      end
    end
  end
endmodule

/* dv/ram_model.sv */
/*
  Data RAM stand-in: returns a word derived from the pointer.
  Assumes the pointer is stable while the op runs.
*/
`timescale 1ns/100ps
module ram_model (
  input wire logic [9:0] ptr_i, // RAM address
  output logic [3:0] rdata_o // Word at address
);
  // Word is low pointer nibble xor 9
  assign rdata_o = ptr_i[3:0] ^ 4'h9;
endmodule

/* dv/nibble_cpu_checker.sv */
/*
  Assertions on the transfer and skip block ports.
  Assumes one clock and synchronous active low reset.
*/
`timescale 1ns/100ps
module nibble_cpu_checker (
  input wire logic mclk_i, // Clock
  input wire logic resetn_i, // Reset
  input wire logic start_i, // Start
  input wire logic busy_o, // Busy
  input wire logic done_o, // Done
  input wire logic nullified_o, // Nullified
  input wire logic [13:0] instruction_counter_o, // Counter
  input wire logic [3:0] acc_o, // Accumulator
  input wire logic [3:0] b_o, // B
  input wire logic [7:0] e_o, // E
  input wire logic [2:0] d_register_o, // D
  input wire logic [2:0] return_stack_index_o // Index
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  done_busy_a: assert property (done_o |-> busy_o) else $error("done without busy");
  null_done_a: assert property (nullified_o |-> done_o) else $error("null without done");
  done_idle_a: assert property (done_o |=> !busy_o) else $error("busy after done");
  take_busy_a: assert property (start_i && !busy_o |=> busy_o) else $error("op not taken");
  done_bound_a: assert property (start_i && !busy_o |-> ##[1:3] done_o) else $error("no done");
  null_data_a: assert property (nullified_o |=> $stable(acc_o) && $stable(b_o) && $stable(e_o)
    && $stable(d_register_o)) else $error("null changed data");
  null_stack_a: assert property (nullified_o |=> $stable(return_stack_index_o))
    else $error("null moved stack");
  null_step_a: assert property (nullified_o |=> instruction_counter_o ==
    $past(instruction_counter_o) + 14'h0001) else $error("null counter step");
endmodule
bind nibble_cpu_transfer_skip nibble_cpu_checker i_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .start_i(start_i), .busy_o(busy_o), .done_o(done_o), .nullified_o(nullified_o),
  .instruction_counter_o(instruction_counter_o), .acc_o(acc_o), .b_o(b_o), .e_o(e_o),
  .d_register_o(d_register_o), .return_stack_index_o(return_stack_index_o));

/* dv/tb_top.sv */
/*
  Self-checking bench for the transfer and skip block.
  Assumes the RAM stand-in and the bound checker.
*/
`timescale 1ns/100ps
module tb_top;
  import nibble_core_pkg::*;
  logic mclk_i = 0, resetn_i = 0, start_i = 0, skip_i = 0, busy_o, done_o, nullified_o, nl;
  op_t op_i = OP_NOP;
  logic [3:0] imm_i = 4'h0, ram_rdata_i, acc_o, b_o;
  logic [13:0] target_i = 14'h0000, pc_o, pc0, ret_pc;
  logic [1:0] cycles_i = 2'h1;
  logic [9:0] ptr_o;
  logic [7:0] e_o;
  logic [2:0] d_o, idx_o;
  int n_errors = 0, n_checks = 0, n;
  nibble_cpu_transfer_skip i_nibble_cpu_transfer_skip (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .start_i(start_i), .op_i(op_i), .imm_i(imm_i), .target_i(target_i), .skip_i(skip_i),
    .cycles_i(cycles_i), .ram_rdata_i(ram_rdata_i), .busy_o(busy_o), .done_o(done_o),
    .nullified_o(nullified_o), .ram_pointer_o(ptr_o), .instruction_counter_o(pc_o),
    .acc_o(acc_o), .b_o(b_o), .e_o(e_o), .d_register_o(d_o), .return_stack_index_o(idx_o));
  ram_model i_ram_model (.ptr_i(ptr_o), .rdata_o(ram_rdata_i));
  always #12.5 mclk_i = ~mclk_i;
  task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One op: drive on falling edge, count cycles to done
  task automatic run(input op_t o, input logic [3:0] j, input logic [1:0] c, input logic s);
    @(negedge mclk_i);
    op_i = o;
    imm_i = j;
    cycles_i = c;
    skip_i = s;
    start_i = 1;
    pc0 = pc_o;
    @(negedge mclk_i);
    start_i = 0;
    n = 1;
    while (done_o !== 1'b1 && n < 9) begin
      @(negedge mclk_i);
      n++;
    end
    nl = nullified_o;
    @(negedge mclk_i);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic test_moves;
    run(OP_RAM_XOR_X, 4'h5, 1, 0); check("ram acc", acc_o, 9);
    check("ptr", ptr_o, 10'h005);
    run(OP_ACC_TO_B, 0, 1, 0); check("b", b_o, 9);
    run(OP_RAM_XOR_X, 4'hF, 2, 0); check("ram x", ptr_o, 10'h00A);
    run(OP_ACC_TO_Y, 0, 1, 0); check("ptr yx", ptr_o, 10'h0CA);
    run(OP_RAM_XOR_X, 0, 1, 0); check("ram", acc_o, 3);
    run(OP_BA_TO_E, 0, 1, 0); check("e", e_o, 8'h93);
    run(OP_ACC_TO_D, 0, 1, 0); check("d", d_o, 3);
    run(OP_IDX_TO_ACC, 0, 1, 0); check("idx to acc", acc_o, 7);
    run(OP_Y_TO_ACC, 0, 1, 0); check("y to acc", acc_o, 4'hC);
    run(OP_D_TO_ACC, 0, 1, 0); check("d keeps a3", acc_o, 4'hB);
    run(OP_Y_TO_ACC, 0, 1, 0);
    run(OP_Z_TO_ACC, 0, 1, 0); check("z to acc", acc_o, 4);
    run(OP_B_TO_ACC, 0, 1, 0); check("b to acc", acc_o, 9);
    run(OP_X_TO_ACC, 0, 1, 0); check("x to acc", acc_o, 4'hA);
    run(OP_ACC_TO_B, 0, 1, 0); check("b again", b_o, 4'hA);
    run(OP_E_TO_BA, 0, 1, 0); check("e to b", b_o, 9);
    check("e to acc", acc_o, 3);
    $display("test moves done");
  endtask
  task automatic test_skip;
    run(OP_NOP, 0, 1, 1);
    run(OP_ACC_TO_B, 0, 3, 0); check("n", n, 3); check("null", nl, 1);
    check("b kept", b_o, 9); check("pc", pc_o, pc0 + 1);
    run(OP_NOP, 0, 1, 1);
    run(OP_RET, 0, 3, 0); check("ret n", n, 1); check("idx", idx_o, 7);
    run(OP_NOP, 0, 1, 1);
    run(OP_TABLE_REF, 0, 2, 0); check("tbl n", n, 1); check("tbl pc", pc_o, pc0 + 1);
    run(OP_Y_TO_ACC, 0, 2, 0); check("after", nl, 0); check("n2", n, 2);
    $display("test skip done");
  endtask
  // Call pushes the return address, return pops it
  task automatic test_stack;
    target_i = 14'h0155;
    run(OP_CALL, 0, 2, 0); check("call pc", pc_o, 14'h0155);
    check("push idx", idx_o, 0);
    ret_pc = pc0 + 14'h0001;
    check("page", pc_o[13:7], 7'h02);
    run(OP_X_TO_ACC, 0, 1, 0);
    run(OP_RET, 0, 3, 0); check("ret pc", pc_o, ret_pc); check("pop idx", idx_o, 7);
    check("ret n", n, 3);
    $display("test stack done");
  endtask
  // Mid-run reset drops a pending skip and the registers
  task automatic test_reset;
    run(OP_NOP, 0, 1, 1);
    resetn_i = 0;
    @(negedge mclk_i);
    resetn_i = 1;
    check("rst pc", pc_o, 0); check("rst idx", idx_o, 7); check("rst acc", acc_o, 0);
    run(OP_ACC_TO_B, 0, 1, 0); check("rst skip", nl, 0); check("rst step", pc_o, 1);
    $display("test reset done");
  endtask
  initial begin
    repeat (8) @(negedge mclk_i);
    resetn_i = 1;
    check("idx rst", idx_o, 7);
    check("pc rst", pc_o, 0);
    test_moves();
    test_skip();
    test_stack();
    test_reset();
    report_and_stop();
  end
  initial begin
    #50000;
    n_errors++;
    report_and_stop();
  end
endmodule
